// file: pkg/adcpo_params.svh
// Purpose: Offsets, field positions, reset values and counts of the ADC output control
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Definitions only
`ifndef ADCPO_PARAMS_SVH
`define ADCPO_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADCPO_CTRL_OFS     12'h000
`define ADCPO_STATUS_OFS   12'h004
`define ADCPO_SAMPLE_OFS   12'h008

// ----------------------------------------------------------------
// Control field positions and reset value
// ----------------------------------------------------------------
`define ADCPO_CTRL_FMT_BIT  0
`define ADCPO_CTRL_OEN_BIT  1
`define ADCPO_CTRL_DCS_BIT  2
`define ADCPO_CTRL_FPD_BIT  3
`define ADCPO_CTRL_PPD_BIT  4
`define ADCPO_CTRL_WIDTH    5
`define ADCPO_CTRL_RESET    5'h00

// ----------------------------------------------------------------
// Status field positions (bit 0 is write-one-to-clear)
// ----------------------------------------------------------------
`define ADCPO_STAT_DUTY_BIT 0
`define ADCPO_STAT_OVR_BIT  1
`define ADCPO_STAT_PWR_LSB  2

// ----------------------------------------------------------------
// Conversion timing
// ----------------------------------------------------------------
`define ADCPO_WORD_BITS     12
`define ADCPO_LATENCY       5
`define ADCPO_DUTY_MIN_PCT  17'd35
`define ADCPO_DUTY_MAX_PCT  17'd65
`define ADCPO_PCT_SCALE     17'd100

`endif

// file: pkg/adcpo_pkg.sv
// Purpose: Types shared by the ADC output control
// Assumes: Constants come from adcpo_params.svh
// Notes:   Types only
package adcpo_pkg;

  typedef logic [11:0] adcpo_word_t;

  typedef enum logic [1:0] {
    ADCPO_RUN,
    ADCPO_QUASI_DOWN,
    ADCPO_FULL_DOWN
  } adcpo_pwr_t;

endpackage : adcpo_pkg

// file: core/adcpo_core.sv
// Purpose: Sampling pipeline, output coding, three-state and power control of a 12-bit ADC
// Assumes: All inputs synchronous to clk; convert clock sampled as a level
// Notes:   Control pins are held in an APB control register
`timescale 1ns/1ps
`include "adcpo_params.svh"

module adcpo_core (
  input  wire logic        clk,               // 25 MHz system clock
  input  wire logic        reset_n,           // Synchronous reset, active low
  input  wire logic        convert_clk_in,    // Convert clock, sampled level
  input  wire logic [11:0] quantizer_code,    // Raw offset-binary quantizer result
  input  wire logic        quantizer_over,    // Quantizer saw input beyond full scale
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB direction
  input  wire logic [11:0] paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error on unmapped address
  output logic      [11:0] sample_data,       // Data bus value, sample_bit_top is bit 11
  output logic             sample_data_oe,    // High while the data bus is driven
  output logic             over_range_flag,   // Over-range of the word on the bus
  output logic             dcs_clock          // Regenerated 50% convert clock
);

  localparam int LAT = `ADCPO_LATENCY;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    unique case (a)
      `ADCPO_CTRL_OFS:   reg_sel = 2'h1;
      `ADCPO_STATUS_OFS: reg_sel = 2'h2;
      `ADCPO_SAMPLE_OFS: reg_sel = 2'h3;
      default:           reg_sel = 2'h0;
    endcase
  endfunction : reg_sel

  function automatic adcpo_pkg::adcpo_word_t code_fmt(input adcpo_pkg::adcpo_word_t w,
                                                      input logic twos);
    code_fmt = {w[11] ^ twos, w[10:0]};
  endfunction : code_fmt

  logic [`ADCPO_CTRL_WIDTH-1:0] ctrl_q;
  logic                         conv_prev_q;
  logic                         launch;
  logic                         fmt_twos, oe_n, dcs_on, full_pd, part_pd;
  adcpo_pkg::adcpo_pwr_t        pwr_q;
  adcpo_pkg::adcpo_word_t       pipe_q [LAT];
  logic [LAT-1:0]               pipe_ovr_q;
  logic [LAT-1:0]               pipe_v_q;
  logic                         out_load;
  logic [7:0]                   hi_cnt_q, lo_cnt_q;
  logic [16:0]                  period;
  logic                         duty_bad, duty_err_q;
  logic                         apb_acc, apb_wr;
  logic [1:0]                   sel;

  assign fmt_twos = ctrl_q[`ADCPO_CTRL_FMT_BIT];
  assign oe_n     = ctrl_q[`ADCPO_CTRL_OEN_BIT];
  assign dcs_on   = ctrl_q[`ADCPO_CTRL_DCS_BIT];
  assign full_pd  = ctrl_q[`ADCPO_CTRL_FPD_BIT];
  assign part_pd  = ctrl_q[`ADCPO_CTRL_PPD_BIT];
  assign launch   = convert_clk_in & ~conv_prev_q;
  assign out_load = launch & (pwr_q == adcpo_pkg::ADCPO_RUN) & pipe_v_q[LAT-1];
  assign sel      = reg_sel(paddr);
  assign apb_acc  = psel & penable & pready;
  assign apb_wr   = apb_acc & pwrite & (sel != 2'h0);

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (sel == 2'h0);
      prdata  <= 32'h00000000;
      if (psel & penable & ~pready & ~pwrite)
      begin
        unique case (sel)
          2'h1: prdata <= {27'h0, ctrl_q};
          2'h2: prdata <= {28'h0, 2'(pwr_q), over_range_flag, duty_err_q};
          2'h3: prdata <= {20'h0, sample_data};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Reset value keeps the enable low, standing in for the pin pull-down
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ctrl_q <= `ADCPO_CTRL_RESET;
    else if (apb_wr && sel == 2'h1)
      ctrl_q <= pwdata[`ADCPO_CTRL_WIDTH-1:0];
  end

  // ----------------------------------------------------------------
  // Power state; full power-down outranks the partial one
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      pwr_q <= adcpo_pkg::ADCPO_RUN;
    else if (full_pd)
      pwr_q <= adcpo_pkg::ADCPO_FULL_DOWN;
    else if (part_pd)
      pwr_q <= adcpo_pkg::ADCPO_QUASI_DOWN;
    else
      pwr_q <= adcpo_pkg::ADCPO_RUN;
  end

  // ----------------------------------------------------------------
  // Conversion pipeline
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      conv_prev_q <= 1'b0;
    else
      conv_prev_q <= convert_clk_in;
  end

  // Quasi power-down freezes the pipe, standard power-down empties it
  genvar gi;
  generate
    for (gi = 0; gi < LAT; gi++)
    begin : g_stage
      adcpo_pkg::adcpo_word_t src_w;
      logic                   src_ovr;
      logic                   src_v;
      // Head stage takes the quantizer, the others take the stage below
      if (gi == 0)
      begin : g_head
        assign src_w   = quantizer_code;
        assign src_ovr = quantizer_over;
        assign src_v   = 1'b1;
      end
      else
      begin : g_tail
        assign src_w   = pipe_q[gi-1];
        assign src_ovr = pipe_ovr_q[gi-1];
        assign src_v   = pipe_v_q[gi-1];
      end
      always_ff @(posedge clk)
      begin
        if (!reset_n || pwr_q == adcpo_pkg::ADCPO_FULL_DOWN)
        begin
          pipe_q[gi]     <= 12'h000;
          pipe_ovr_q[gi] <= 1'b0;
          pipe_v_q[gi]   <= 1'b0;
        end
        else if (launch && pwr_q == adcpo_pkg::ADCPO_RUN)
        begin
          pipe_q[gi]     <= src_w;
          pipe_ovr_q[gi] <= src_ovr;
          pipe_v_q[gi]   <= src_v;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output word, flag and three-state
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sample_data     <= 12'h000;
      over_range_flag <= 1'b0;
    end
    else if (pwr_q == adcpo_pkg::ADCPO_FULL_DOWN)
    begin
      sample_data     <= 12'h000;
      over_range_flag <= 1'b0;
    end
    else if (out_load)
    begin
      sample_data     <= code_fmt(pipe_q[LAT-1], fmt_twos);
      over_range_flag <= pipe_ovr_q[LAT-1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sample_data_oe <= 1'b1;
    else
      sample_data_oe <= ~oe_n;
  end

  // ----------------------------------------------------------------
  // Duty-cycle stabilizer: measures high and low time of the convert
  // clock and regenerates an even half-period square wave
  // ----------------------------------------------------------------
  // The launch cycle is the last low cycle of the period just ended
  assign period   = 17'(hi_cnt_q) + 17'(lo_cnt_q) + 17'h00001;
  assign duty_bad = (17'(hi_cnt_q) * `ADCPO_PCT_SCALE < `ADCPO_DUTY_MIN_PCT * period) ||
                    (17'(hi_cnt_q) * `ADCPO_PCT_SCALE > `ADCPO_DUTY_MAX_PCT * period);

  // Counters saturate, so very slow convert clocks are judged on the first 255 cycles of each phase
  always_ff @(posedge clk)
  begin
    if (!reset_n || launch)
    begin
      hi_cnt_q <= 8'h00;
      lo_cnt_q <= 8'h00;
    end
    else if (conv_prev_q && hi_cnt_q != 8'hFF)
      hi_cnt_q <= hi_cnt_q + 8'h01;
    else if (!conv_prev_q && lo_cnt_q != 8'hFF)
      lo_cnt_q <= lo_cnt_q + 8'h01;
  end

  // Sticky; a new violation wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      duty_err_q <= 1'b0;
    else if (launch && dcs_on && period != 17'h0 && duty_bad)
      duty_err_q <= 1'b1;
    else if (apb_wr && sel == 2'h2 && pwdata[`ADCPO_STAT_DUTY_BIT])
      duty_err_q <= 1'b0;
  end

  // Regenerated clock: rises on launch, falls after half the measured period
  logic [7:0] half_cnt_q;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dcs_clock  <= 1'b0;
      half_cnt_q <= 8'h00;
    end
    else if (!dcs_on)
    begin
      dcs_clock  <= conv_prev_q;
      half_cnt_q <= 8'h00;
    end
    else if (launch)
    begin
      dcs_clock  <= 1'b1;
      half_cnt_q <= period[8:1];
    end
    else if (half_cnt_q > 8'h01)
      half_cnt_q <= half_cnt_q - 8'h01;
    else
    begin
      half_cnt_q <= 8'h00;
      dcs_clock  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_launch_capture: assert property (@(posedge clk) disable iff (!reset_n)
    launch && pwr_q == adcpo_pkg::ADCPO_RUN && !full_pd |=> pipe_v_q[0]
      && pipe_q[0] == $past(quantizer_code))
    else $error("launch did not capture the quantizer word");

  chk_format_code: assert property (@(posedge clk) disable iff (!reset_n)
    out_load && !full_pd |=> sample_data[11] == ($past(pipe_q[LAT-1][11]) ^ $past(fmt_twos))
      && sample_data[10:0] == $past(pipe_q[LAT-1][10:0]))
    else $error("output coding does not follow format select");

  chk_oe_follow: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(oe_n) |=> ##1 sample_data_oe == !$past(oe_n, 2))
    else $error("bus enable does not follow output enable");

  chk_oe_default: assert property (@(posedge clk)
    $rose(reset_n) |-> sample_data_oe && !oe_n)
    else $error("bus not driven after reset");

  chk_duty_only_dcs: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(duty_err_q) |-> $past(dcs_on) && $past(launch))
    else $error("duty error raised with stabilizer off");

  chk_full_down: assert property (@(posedge clk) disable iff (!reset_n)
    full_pd ##1 full_pd |=> pipe_v_q == '0 && sample_data == 12'h000)
    else $error("standard power-down left data in the pipe");

  chk_quasi_hold: assert property (@(posedge clk) disable iff (!reset_n)
    pwr_q == adcpo_pkg::ADCPO_QUASI_DOWN && !full_pd |=> $stable(sample_data)
      && $stable(pipe_v_q))
    else $error("quasi power-down let the pipe move");

  chk_ovr_align: assert property (@(posedge clk) disable iff (!reset_n)
    out_load && !full_pd |=> over_range_flag == $past(pipe_ovr_q[LAT-1]))
    else $error("over-range flag not aligned with its word");

  chk_apb_wait: assert property (@(posedge clk) disable iff (!reset_n)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

endmodule : adcpo_core

// file: dv/adcpo_capture.sv
// Purpose: Far-side capture model: convert clock source and data bus resolver
// Assumes: Phase lengths given in clk cycles, each at least one
// Notes:   A released bus shows the inverse of its last driven word
`timescale 1ns/1ps

module adcpo_capture (
  input  wire logic        clk,     // System clock
  input  wire logic        reset_n, // Synchronous reset, active low
  input  wire logic        run,     // Produce convert edges
  input  wire logic [7:0]  hi_cyc,  // High phase length
  input  wire logic [7:0]  lo_cyc,  // Low phase length
  input  wire logic [11:0] data_in, // Device data outputs
  input  wire logic        data_oe, // Device drives the bus
  output logic             conv,    // Convert clock to the device
  output logic             launch,  // Device sees a rise at this edge
  output logic      [11:0] bus      // Resolved bus level
);
  logic [7:0]  cnt_q;
  logic        prev_q;
  logic [11:0] last_q;

  // Stopping forces the clock low, so a rise never follows a rise directly
  always_ff @(posedge clk)
  begin
    if (!reset_n || !run)
    begin
      conv  <= 1'b0;
      cnt_q <= 8'h00;
    end
    else if (cnt_q + 8'h01 >= (conv ? hi_cyc : lo_cyc))
    begin
      conv  <= !conv;
      cnt_q <= 8'h00;
    end
    else
      cnt_q <= cnt_q + 8'h01;
  end

  always_ff @(posedge clk)
    prev_q <= conv;

  // The word of a launch is expected five launches later
  assign launch = conv && !prev_q;

  always_ff @(posedge clk)
    if (data_oe)
      last_q <= data_in;

  // No pull on the bus, so a stale word must not survive release
  assign bus = data_oe ? data_in : ~last_q;
endmodule : adcpo_capture

// file: dv/adcpo_core_test.sv
// Purpose: Self-checking bench of the ADC output control
// Assumes: The capture model supplies the convert clock
// Notes:   Random codes from a fixed seed, corner codes mixed in
`timescale 1ns/1ps
`include "adcpo_params.svh"

module adcpo_core_test;
  logic        clk, reset_n, psel, penable, pwrite, over_in, run;
  logic        pready, pslverr, sample_data_oe, over_range_flag, dcs_clock;
  logic        conv, launch, err, fmt, track, cmp_pend, chk_dcs;
  logic [1:0]  conv_d;
  logic [11:0] code_in, paddr, sample_data, bus;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  hi_cyc, lo_cyc;
  logic [12:0] exp_w, held_w, q[$];
  int          mismatches, comparisons, launches, cycles;
  logic [11:0] corner [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
  logic [16:0] duty [5] = '{{1'b0, 8'h02, 8'h02}, {1'b0, 8'h07, 8'h0D},
    {1'b0, 8'h0D, 8'h07}, {1'b1, 8'h06, 8'h0E}, {1'b1, 8'h0E, 8'h06}};

  adcpo_core adcpo_core_inst (.clk(clk), .reset_n(reset_n), .convert_clk_in(conv),
    .quantizer_code(code_in), .quantizer_over(over_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_data(sample_data),
    .sample_data_oe(sample_data_oe), .over_range_flag(over_range_flag),
    .dcs_clock(dcs_clock));

  adcpo_capture adcpo_capture_inst (.clk(clk), .reset_n(reset_n), .run(run),
    .hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .data_in(sample_data),
    .data_oe(sample_data_oe), .conv(conv), .launch(launch), .bus(bus));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_word(input logic [12:0] got, input logic [12:0] exp);
    chk_reg({19'h0, got}, {19'h0, exp});
  endtask : chk_word

  task automatic results();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Convert edges pause while the mode changes, so no launch straddles it
  task automatic set_ctrl(input logic [4:0] c);
    run <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b1, `ADCPO_CTRL_OFS, {27'h0, c});
    fmt   = c[0];
    track = (c[4:3] == 2'b00);
    repeat (3) @(posedge clk);
    run <= !c[1];
    @(posedge clk);
  endtask : set_ctrl

  task automatic wait_launch(input int n);
    int s;
    s = launches;
    while (launches < s + n)
      @(posedge clk);
  endtask : wait_launch

  // ----------------------------------------------------------------
  // Monitor and stimulus
  // ----------------------------------------------------------------
  // Watchdog: a hang ends the run as a failure
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      mismatches++;
      results();
    end
  end

  always @(posedge clk)
  begin
    if (cmp_pend)
      chk_word({over_range_flag, bus}, exp_w);
    cmp_pend = 1'b0;
    if (chk_dcs)
      chk_reg({31'h0, dcs_clock}, {31'h0, conv_d[1]});
    conv_d = {conv_d[0], conv};
    if (launch === 1'b1)
    begin
      launches++;
      if (track)
        q.push_back({over_in, code_in});
      if (track && q.size() > 5)
      begin
        exp_w    = q.pop_front() ^ {1'b0, fmt, 11'h000};
        held_w   = exp_w;
        cmp_pend = 1'b1;
      end
    end
    code_in <= ($urandom % 4 == 0) ? corner[$urandom % 4] : 12'($urandom);
    over_in <= 1'($urandom);
  end

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    void'($urandom(32'h95CD));
    {reset_n, psel, penable, pwrite, run, track, fmt, cmp_pend, chk_dcs} = '0;
    {paddr, pwdata, code_in, over_in, conv_d} = '0;
    hi_cyc = 8'h02;
    lo_cyc = 8'h03;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk_reg({31'h0, sample_data_oe}, 32'h1);
    apb(1'b0, `ADCPO_CTRL_OFS, 32'h0);
    chk_reg(rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk_reg({31'h0, err}, 32'h1);
    chk_dcs = 1'b1;
    for (int f = 0; f < 4; f++)
    begin
      hi_cyc <= 8'h01 + 8'($urandom % 4);
      set_ctrl({4'h0, f[0]});
      wait_launch(25);
    end
    set_ctrl(5'h02);
    chk_reg({31'h0, sample_data_oe}, 32'h0);
    set_ctrl(5'h00);
    chk_reg({31'h0, sample_data_oe}, 32'h1);
    set_ctrl(5'h10);
    wait_launch(8);
    chk_word({over_range_flag, sample_data}, held_w);
    apb(1'b0, `ADCPO_STATUS_OFS, 32'h0);
    chk_reg(rd & 32'h0000000C, 32'h4);
    set_ctrl(5'h00);
    wait_launch(12);
    set_ctrl(5'h18);
    wait_launch(4);
    chk_word({over_range_flag, sample_data}, 13'h0000);
    apb(1'b0, `ADCPO_STATUS_OFS, 32'h0);
    chk_reg(rd & 32'h0000000C, 32'h8);
    q.delete();
    set_ctrl(5'h01);
    wait_launch(15);
    chk_dcs = 1'b0;
    set_ctrl(5'h04);
    foreach (duty[i])
    begin
      hi_cyc <= duty[i][15:8];
      lo_cyc <= duty[i][7:0];
      wait_launch(3);
      apb(1'b1, `ADCPO_STATUS_OFS, 32'h1);
      wait_launch(3);
      apb(1'b0, `ADCPO_STATUS_OFS, 32'h0);
      chk_reg(rd & 32'h1, {31'h0, duty[i][16]});
    end
    results();
  end
endmodule : adcpo_core_test
